// >>> hdl/srbc_pkg.sv
/*
 * Constants and types for the register comparator block.
 * Assumes a single 40 MHz clock domain and an APB master on that clock.
 */
package srbc_pkg;

	// ==========================================================
	// Data path
	localparam int WIDTH = 8;

	// Function select code, written as {func_select_lo, func_select_hi}
	typedef enum logic [1:0] {
		FN_HOLD = 2'b00,
		FN_READ = 2'b01,
		FN_SHIFT = 2'b10,
		FN_LOAD = 2'b11
	} srbc_func_e;

	// ==========================================================
	// Register map, byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DATA = 8'h08;

	// Control register fields
	localparam int CTRL_OVERRIDE = 0;
	localparam int CTRL_SEL_HI = 1;
	localparam int CTRL_SEL_LO = 2;
	localparam int CTRL_MODE = 3;
	localparam int CTRL_SE_N = 4;
	localparam int CTRL_BITS = 5;
	localparam logic [CTRL_BITS-1:0] CTRL_RESET = 5'h10;

	// Status register fields
	localparam int STAT_EQ = 8;
	localparam int STAT_GT = 9;
	localparam int STAT_LT = 10;
	localparam int STAT_PRIO = 11;

	// Values after reset
	localparam logic [WIDTH-1:0] STORED_RESET = 8'h00;

endpackage

// >>> hdl/srbc_top.sv
/*
 * Eight-bit shift register with bus comparator and chaining pins.
 * Assumes pins arrive asynchronously and are synchronised here, and that
 * an external wire resolves open-drain flags and the three-state bus.
 */
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Eight-bit register, shifts from MSB toward LSB
// - All register updates on rising clock edge except the asynchronous reset
// - Both selects low: register holds
// - Read code: drive register onto bus
// - Shift code: one shift per edge
// - Both selects high: load bus byte
// - Bus drivers enabled only when reading
// - Serial in from priority input, out
// - Compare register with bus byte continuously
// - Flags open-drain, true means released
// - Status disabled releases all three flags
// - Mode low unsigned, high signed compare
// - Priority input low turns greater/less off
// - Priority output high on equality with priority input high
// - Greater: equal, less low; greater released
// - Less: equal, greater low; priority low
// - Outside shift, priority out shows equality gated by priority in
module srbc_top
	import srbc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Function and compare control pins
	input wire logic funcSelectLo,
	input wire logic funcSelectHi,
	input wire logic statusEnable_n,
	input wire logic compareMode,
	// Priority or serial chain
	input wire logic prioSerialIn,
	output logic prioSerialOut,
	// Parallel bus, three-state
	input wire logic [WIDTH-1:0] parallelBusIn,
	output logic [WIDTH-1:0] parallelBusOut,
	output logic parallelBusOe_n,
	// Open-drain flags
	output logic flagEqualOut,
	output logic flagEqualOe_n,
	output logic flagGreaterOut,
	output logic flagGreaterOe_n,
	output logic flagLessOut,
	output logic flagLessOe_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [1:0] selMeta;
		logic [1:0] selSync;
		logic seMeta;
		logic seSync;
		logic modeMeta;
		logic modeSync;
		logic ciMeta;
		logic ciSync;
		logic [WIDTH-1:0] busMeta;
		logic [WIDTH-1:0] busSync;
		logic [WIDTH-1:0] stored;
		logic [CTRL_BITS-1:0] ctrl;
		logic prioOut;
		logic [WIDTH-1:0] busOut;
		logic busOe_n;
		logic eqOe_n;
		logic gtOe_n;
		logic ltOe_n;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
	} srbc_state_s;

	srbc_state_s s;
	srbc_state_s next_s;

	srbc_func_e fnEff;
	logic seEff;
	logic modeEff;
	logic isEqual;
	logic isGreater;
	logic isLess;
	logic apbAccess;

	// ==========================================================
	// Compare as unsigned or two's complement
	function automatic logic srbc_greater(input logic [WIDTH-1:0] a,
		input logic [WIDTH-1:0] b, input logic signedMode);
		if (signedMode) begin
			srbc_greater = $signed(a) > $signed(b);
		end else begin
			srbc_greater = a > b;
		end
	endfunction

	// ==========================================================
	// Effective controls: pins, or software override
	always_comb begin
		if (s.ctrl[CTRL_OVERRIDE]) begin
			fnEff = srbc_func_e'({s.ctrl[CTRL_SEL_LO], s.ctrl[CTRL_SEL_HI]});
			seEff = s.ctrl[CTRL_SE_N];
			modeEff = s.ctrl[CTRL_MODE];
		end else begin
			fnEff = srbc_func_e'(s.selSync);
			seEff = s.seSync;
			modeEff = s.modeSync;
		end
		isEqual = s.stored == s.busSync;
		isGreater = srbc_greater(s.stored, s.busSync, modeEff);
		isLess = srbc_greater(s.busSync, s.stored, modeEff);
		apbAccess = psel && penable && !s.ready;
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_s = s;
		// Two-stage synchronisers
		next_s.selMeta = {funcSelectLo, funcSelectHi};
		next_s.selSync = s.selMeta;
		next_s.seMeta = statusEnable_n;
		next_s.seSync = s.seMeta;
		next_s.modeMeta = compareMode;
		next_s.modeSync = s.modeMeta;
		next_s.ciMeta = prioSerialIn;
		next_s.ciSync = s.ciMeta;
		next_s.busMeta = parallelBusIn;
		next_s.busSync = s.busMeta;

		// Register operation
		unique case (fnEff)
			FN_HOLD: next_s.stored = s.stored;
			FN_READ: next_s.stored = s.stored;
			FN_SHIFT: next_s.stored = {s.ciSync, s.stored[WIDTH-1:1]};
			FN_LOAD: next_s.stored = s.busSync;
		endcase

		// Bus drivers
		next_s.busOut = s.stored;
		next_s.busOe_n = fnEff != FN_READ;

		// Flags, released when true
		next_s.eqOe_n = seEff || isEqual;
		next_s.gtOe_n = seEff || !s.ciSync || isGreater;
		next_s.ltOe_n = seEff || !s.ciSync || isLess;

		// Priority or serial out
		if (fnEff == FN_SHIFT) begin
			next_s.prioOut = s.stored[0];
		end else begin
			next_s.prioOut = s.ciSync && isEqual;
		end

		// APB slave, one wait state
		next_s.ready = apbAccess;
		next_s.slverr = 1'b0;
		next_s.rdata = 32'h0000_0000;
		if (apbAccess) begin
			unique case (paddr)
				ADDR_CTRL: next_s.rdata = {27'h0, s.ctrl};
				ADDR_STATUS: next_s.rdata = {20'h0, s.prioOut, !s.ltOe_n,
					!s.gtOe_n, !s.eqOe_n, s.stored} ^ 32'h0000_0700;
				ADDR_DATA: next_s.rdata = {24'h0, s.stored};
				default: next_s.slverr = 1'b1;
			endcase
		end
		if (psel && penable && s.ready && pwrite && paddr == ADDR_CTRL) begin
			next_s.ctrl = pwdata[CTRL_BITS-1:0];
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.stored <= STORED_RESET;
			s.ctrl <= CTRL_RESET;
			// Status enable starts at its idle, disabled level
			s.seMeta <= 1'b1;
			s.seSync <= 1'b1;
			s.busOe_n <= 1'b1;
			s.eqOe_n <= 1'b1;
			s.gtOe_n <= 1'b1;
			s.ltOe_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign prioSerialOut = s.prioOut;
	assign parallelBusOut = s.busOut;
	assign parallelBusOe_n = s.busOe_n;
	assign flagEqualOut = 1'b0;
	assign flagEqualOe_n = s.eqOe_n;
	assign flagGreaterOut = 1'b0;
	assign flagGreaterOe_n = s.gtOe_n;
	assign flagLessOut = 1'b0;
	assign flagLessOe_n = s.ltOe_n;
	assign prdata = s.rdata;
	assign pready = s.ready;
	assign pslverr = s.slverr;

	// ==========================================================
	// Checks
	a_hold_keeps: assert property (@(posedge clk) disable iff (!rst_n)
		fnEff == FN_HOLD |=> s.stored == $past(s.stored))
		else $error("Hold changed the register");
	a_shift_moves: assert property (@(posedge clk) disable iff (!rst_n)
		fnEff == FN_SHIFT |=>
		s.stored == {$past(s.ciSync), $past(s.stored[WIDTH-1:1])})
		else $error("Shift did not move one place");
	a_load_takes: assert property (@(posedge clk) disable iff (!rst_n)
		fnEff == FN_LOAD |=> s.stored == $past(s.busSync))
		else $error("Load did not take the bus byte");
	a_read_drives: assert property (@(posedge clk) disable iff (!rst_n)
		fnEff == FN_READ |=> !parallelBusOe_n && parallelBusOut ==
		$past(s.stored) && s.stored == $past(s.stored))
		else $error("Read did not drive the register");
	a_bus_released: assert property (@(posedge clk) disable iff (!rst_n)
		fnEff != FN_READ |=> parallelBusOe_n)
		else $error("Bus driven outside read");
	a_flags_off: assert property (@(posedge clk) disable iff (!rst_n)
		seEff |=> flagEqualOe_n && flagGreaterOe_n && flagLessOe_n)
		else $error("Flags pulled while status disabled");
	a_prio_gates: assert property (@(posedge clk) disable iff (!rst_n)
		!s.ciSync |=> flagGreaterOe_n && flagLessOe_n)
		else $error("Greater or less pulled with priority low");
	a_equal_flag: assert property (@(posedge clk) disable iff (!rst_n)
		!seEff |=> flagEqualOe_n == ($past(s.stored) == $past(s.busSync)))
		else $error("Equal flag wrong");
	a_greater_case: assert property (@(posedge clk) disable iff (!rst_n)
		!seEff && s.ciSync && isGreater |=>
		!flagEqualOe_n && !flagLessOe_n && flagGreaterOe_n && !prioSerialOut
		|| $past(fnEff) == FN_SHIFT)
		else $error("Greater result wrong");
	a_less_case: assert property (@(posedge clk) disable iff (!rst_n)
		!seEff && s.ciSync && isLess && fnEff != FN_SHIFT |=>
		!flagEqualOe_n && !flagGreaterOe_n && flagLessOe_n && !prioSerialOut)
		else $error("Less result wrong");
	a_prio_equal: assert property (@(posedge clk) disable iff (!rst_n)
		fnEff != FN_SHIFT |=> prioSerialOut ==
		($past(s.ciSync) && $past(s.stored) == $past(s.busSync)))
		else $error("Priority out does not show equality");
	a_serial_out: assert property (@(posedge clk) disable iff (!rst_n)
		fnEff == FN_SHIFT |=> prioSerialOut == $past(s.stored[0]))
		else $error("Serial out is not the last stage");
	a_signed_sign: assert property (@(posedge clk) disable iff (!rst_n)
		!seEff && s.ciSync && modeEff && s.stored[WIDTH-1] &&
		!s.busSync[WIDTH-1] |=> !flagLessOe_n == 1'b0)
		else $error("Negative value not less in signed mode");
	a_less_uns: assert property (@(posedge clk) disable iff (!rst_n)
		!seEff && s.ciSync && !modeEff && s.stored < s.busSync |=>
		flagLessOe_n && !flagGreaterOe_n && !flagEqualOe_n)
		else $error("Unsigned less result wrong");
	a_great_uns: assert property (@(posedge clk) disable iff (!rst_n)
		!seEff && s.ciSync && !modeEff && s.stored > s.busSync |=>
		flagGreaterOe_n && !flagLessOe_n && !flagEqualOe_n)
		else $error("Unsigned greater result wrong");
	a_equal_row: assert property (@(posedge clk) disable iff (!rst_n)
		!seEff && s.ciSync && s.stored == s.busSync |=>
		flagEqualOe_n && !flagGreaterOe_n && !flagLessOe_n)
		else $error("Equal result wrong");
	a_prio_low: assert property (@(posedge clk) disable iff (!rst_n)
		!s.ciSync && fnEff != FN_SHIFT |=> !prioSerialOut)
		else $error("Priority out high with priority in low");
	a_prio_high: assert property (@(posedge clk) disable iff (!rst_n)
		s.ciSync && s.stored == s.busSync && fnEff != FN_SHIFT |=>
		prioSerialOut)
		else $error("Priority out low on equality");
	a_bus_value: assert property (@(posedge clk) disable iff (!rst_n)
		!parallelBusOe_n |-> parallelBusOut == s.stored)
		else $error("Driven bus differs from register");
	a_ready_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		pready |=> !pready)
		else $error("Ready stood longer than one cycle");
	a_error_ready: assert property (@(posedge clk) disable iff (!rst_n)
		pslverr |-> pready)
		else $error("Error shown without ready");
	a_ctrl_kept: assert property (@(posedge clk) disable iff (!rst_n)
		!(psel && penable && pready && pwrite && paddr == ADDR_CTRL) |=>
		$stable(s.ctrl))
		else $error("Control changed without a write");

endmodule

`default_nettype wire

// >>> test/srbc_bus_master.sv
/* Far-side model: bus master that owns the data bus and flag pull-ups.
 * Assumes the bench gives the byte to drive and when to drive it. */
`timescale 1ns/1ps
`default_nettype none
module srbc_bus_master
	import srbc_pkg::*;
(
	// Clock and bench drive
	input wire logic clk,
	input wire logic drvEn,
	input wire logic [WIDTH-1:0] drvVal,
	// Device pins
	input wire logic [WIDTH-1:0] busOut,
	input wire logic busOe_n,
	input wire logic [2:0] flagOut,
	input wire logic [2:0] flagOe_n,
	output logic [WIDTH-1:0] busWire,
	output logic [2:0] flagWire
);
	logic [WIDTH-1:0] last = 8'h00;
	// Undriven bus shows a changing pattern
	assign busWire = !busOe_n ? busOut : drvEn ? drvVal : ~last;
	// Pull-ups, flags wire-ANDed
	assign flagWire = flagOe_n | flagOut;
	always @(posedge clk) begin
		last <= busWire;
	end
endmodule
`default_nettype wire

// >>> test/srbc_top_bench.sv
/* Self-checking bench for the register comparator.
 * Assumes the bus master model and the design package. */
`timescale 1ns/1ps
`default_nettype none
module srbc_top_bench
	import srbc_pkg::*;
;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic funcSelectLo = 1'h0, funcSelectHi = 1'h0, statusEnable_n = 1'h1;
	logic compareMode = 1'h0, prioSerialIn = 1'h0, prioSerialOut;
	logic [WIDTH-1:0] parallelBusIn, parallelBusOut, drvVal = 8'h00;
	logic parallelBusOe_n, drvEn = 1'h0, pready, pslverr, err;
	wire logic [2:0] flagOut, flagOe_n;
	logic [2:0] flagWire;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	int failCount = 0, checked = 0;

	srbc_top u_srbc_top (.clk, .rst_n, .funcSelectLo, .funcSelectHi,
		.statusEnable_n, .compareMode, .prioSerialIn, .prioSerialOut,
		.parallelBusIn, .parallelBusOut, .parallelBusOe_n,
		.flagEqualOut(flagOut[0]), .flagEqualOe_n(flagOe_n[0]),
		.flagGreaterOut(flagOut[1]), .flagGreaterOe_n(flagOe_n[1]),
		.flagLessOut(flagOut[2]), .flagLessOe_n(flagOe_n[2]),
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr);
	srbc_bus_master u_srbc_bus_master (.clk, .drvEn, .drvVal,
		.busOut(parallelBusOut), .busOe_n(parallelBusOe_n), .flagOut,
		.flagOe_n, .busWire(parallelBusIn), .flagWire);

	always #12.5 clk = ~clk;

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failCount++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, failCount);
		if (failCount == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic sel(input logic lo, input logic hi);
		@(posedge clk);
		funcSelectLo <= lo;
		funcSelectHi <= hi;
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_apb();
		apb(1'h0, ADDR_CTRL, 32'h0);
		check(rd, 32'h10);
		apb(1'h1, ADDR_CTRL, 32'h08);
		apb(1'h0, ADDR_CTRL, 32'h0);
		check(rd, 32'h08);
		apb(1'h1, ADDR_CTRL, 32'h10);
		apb(1'h0, 8'h0c, 32'h0);
		check(err, 1'h1);
		apb(1'h0, ADDR_STATUS, 32'h0);
		check(rd, 32'h0000_0700);
		$display("register access done");
	endtask

	task automatic t_load();
		@(posedge clk);
		drvEn <= 1'h1;
		drvVal <= 8'ha5;
		tick(4);
		sel(1'h1, 1'h1);
		sel(1'h0, 1'h0);
		@(posedge clk);
		drvVal <= 8'h3c;
		tick(6);
		apb(1'h0, ADDR_DATA, 32'h0);
		check(rd, 32'ha5);
		@(posedge clk);
		drvEn <= 1'h0;
		sel(1'h0, 1'h1);
		tick(6);
		check({parallelBusOe_n, parallelBusIn}, 9'h0a5);
		sel(1'h0, 1'h0);
		tick(6);
		check(parallelBusOe_n, 1'h1);
		$display("load and read done");
	endtask

	task automatic t_shift();
		@(posedge clk);
		prioSerialIn <= 1'h1;
		sel(1'h1, 1'h0);
		repeat (2) @(posedge clk);
		sel(1'h0, 1'h0);
		tick(1);
		check(prioSerialOut, 1'h0);
		tick(1);
		check(prioSerialOut, 1'h1);
		tick(4);
		apb(1'h0, ADDR_DATA, 32'h0);
		check(rd, 32'hf4);
		$display("shift done");
	endtask

	task automatic t_compare();
		logic [15:0] tb [8] = '{16'h1048, 16'h1064, 16'hf452, 16'hff44,
			16'h100c, 16'hf41c, 16'h10dc, 16'hf4fe};
		foreach (tb[i]) begin
			@(posedge clk);
			drvEn <= 1'h1;
			drvVal <= tb[i][15:8];
			statusEnable_n <= tb[i][7];
			prioSerialIn <= tb[i][6];
			compareMode <= tb[i][5];
			tick(6);
			check(flagWire[0], tb[i][4]);
			check(flagWire[1], tb[i][3]);
			check(flagWire[2], tb[i][2]);
			check(prioSerialOut, tb[i][1]);
		end
		$display("compare done");
	endtask

	// Top of a chain: own priority out fed to own status enable
	task automatic t_chain();
		logic [7:0] bus [2] = '{8'h10, 8'hf4};
		logic [3:0] want [2] = '{4'h4, 4'hf};
		foreach (bus[i]) begin
			@(posedge clk);
			drvEn <= 1'h1;
			drvVal <= bus[i];
			compareMode <= 1'h0;
			prioSerialIn <= 1'h1;
			repeat (10) begin
				@(posedge clk);
				statusEnable_n <= prioSerialOut;
			end
			#1;
			check({flagWire, prioSerialOut}, want[i]);
		end
		$display("chain top done");
	endtask

	// Software override selects read while the pins say hold
	task automatic t_override();
		@(posedge clk);
		drvEn <= 1'h0;
		apb(1'h1, ADDR_CTRL, 32'h13);
		tick(2);
		check({parallelBusOe_n, parallelBusIn}, 9'h0f4);
		apb(1'h1, ADDR_CTRL, 32'h10);
		tick(2);
		check(parallelBusOe_n, 1'h1);
		$display("override done");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		tick(2);
		check({parallelBusOe_n, flagOe_n}, 4'hf);
		t_apb();
		t_load();
		t_shift();
		t_compare();
		t_chain();
		t_override();
		stop_test();
	end

	initial begin
		repeat (5000) @(posedge clk);
		failCount++;
		stop_test();
	end
endmodule
`default_nettype wire
